/* File: dv/prog_master.sv */
/*
 * Programmer model: serial master that clocks commands in and responses out.
 * Assumes the bench resolves the shared data wire and calls these tasks.
 */
`timescale 1ns/1ps
module prog_master (
   // Pins toward the device
   output logic      clk_out,
   output logic      data_out,
   output logic      oe_out,
   // Resolved data wire
   input  wire logic line_in
);
   // ==========================================================
   // Serial master
   // Clock idles low outside frames
   initial begin
      clk_out = 1'b0;
      data_out = 1'b0;
      oe_out = 1'b0;
   end

   // Change on falling edge, 48 ns period, MSB first
   task send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         data_out = w[i];
         oe_out = 1'b1;
         #24 clk_out = 1'b1;
         #24 clk_out = 0;
      end
   endtask

   // Hand the wire over once the command is complete
   task release_line;
      oe_out = 1'b0;
   endtask

   // Sample on rising edge; caller waits for ready first
   task recv_word(output logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         clk_out = 1'b1;
         w[i] = line_in;
         #24 clk_out = 1'b0;
         #24;
      end
   endtask
endmodule

/* File: dv/tb.sv */
/*
 * Bench for the command link: opcode table rows, then reset cases.
 * Assumes the programmer model and the design files are compiled first.
 */
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // Signals
   typedef struct {logic [3:0] op; logic [11:0] len; int kind; int dly;} row_t;
   logic        sys_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        exec_done_in = 1'b0;
   logic [11:0] resp_len_in = 12'h000;
   logic [15:0] resp_word_in = 16'h0000;
   logic        sck, pd, poe, dd, doe, st, av, busy;
   logic [3:0]  opc;
   logic [11:0] len, ai, ri;
   logic [15:0] aw;
   int          num_errors = 0, comparisons = 0, nargs = 0;
   // Kind: 0 sanity, 1 served by core, 2 refused; dly = core cycles
   row_t rows [16] = '{'{4'h0,12'h001,0,0}, '{4'h1,12'h003,1,0}, '{4'h2,12'h004,1,3}, '{4'h3,12'h006,1,0},
      '{4'h5,12'h063,1,20}, '{4'h7,12'h001,1,0}, '{4'h9,12'h003,1,0}, '{4'hb,12'h001,1,5}, '{4'hc,12'h005,1,0},
      '{4'he,12'h005,1,0}, '{4'h4,12'h001,2,0}, '{4'h6,12'h002,2,0}, '{4'h8,12'h001,2,0}, '{4'ha,12'h001,2,0},
      '{4'hd,12'h003,2,0}, '{4'hf,12'h001,2,0}};
   // Undriven wire shows the inverse of the last value, never a kind guess
   wire line = doe ? dd : (poe ? pd : ~pd);

   always #2.5 sys_clk_in = ~sys_clk_in;
   // Core answers one cycle after the index moves
   always @(posedge sys_clk_in) resp_word_in <= 16'ha500 + {4'h0, ri};

   prog_master pm (.clk_out(sck), .data_out(pd), .oe_out(poe), .line_in(line));
   flash_loader_command_link dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .prog_serial_clock_in(sck),
      .prog_serial_data_in(line), .prog_serial_data_out(dd), .prog_serial_data_oe_out(doe), .exec_start_out(st),
      .exec_opcode_out(opc), .exec_length_out(len), .arg_valid_out(av), .arg_word_out(aw), .arg_index_out(ai),
      .exec_done_in(exec_done_in), .resp_len_in(resp_len_in), .resp_word_in(resp_word_in),
      .resp_index_out(ri), .link_busy_out(busy));

   // ==========================================================
   // Checks
   task chk_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Argument words arrive in order, numbered from zero
   always @(posedge sys_clk_in) if (av === 1'b1) begin
      chk_word(aw, 16'h3c00 + nargs[15:0]);
      chk_word({4'h0, ai}, nargs[15:0]);
      nargs++;
   end

   // One full exchange: command, busy, ready, two response words, release
   task run_cmd(input row_t r);
      logic [15:0] w;
      int          n;
      nargs = 0;
      pm.send_word({r.op, r.len});
      for (n = 1; n < r.len; n++) pm.send_word(16'h3c00 + 16'(n - 1));
      pm.release_line();
      // Busy level first, so a released line left low is not taken for ready
      n = 0;
      while (doe !== 1'b1 && n < 100) begin @(posedge sys_clk_in); n++; end
      chk_bit(line, 1'b1);
      if (r.kind == 1) begin
         n = 0;
         while (st !== 1'b1 && n < 100) begin @(posedge sys_clk_in); n++; end
         chk_bit(st, 1'b1);
         chk_word({opc, len}, {r.op, r.len});
         repeat (r.dly) @(posedge sys_clk_in);
         chk_bit(line, 1'b1);
         exec_done_in <= 1'b1;
         resp_len_in <= 12'h002;
         @(posedge sys_clk_in);
         exec_done_in <= 1'b0;
      end
      n = 0;
      while (line !== 1'b0 && n < 200) begin @(posedge sys_clk_in); n++; end
      chk_bit(doe, 1'b1);
      #100;
      pm.recv_word(w);
      chk_word(w, r.kind == 0 ? 16'h1000 : r.kind == 1 ? 16'ha500 : {4'h2, r.op, 8'h00});
      pm.recv_word(w);
      chk_word(w, r.kind == 1 ? 16'ha501 : 16'h0002);
      repeat (6) @(posedge sys_clk_in);
      chk_bit(doe, 1'b0);
      chk_bit(busy, 1'b0);
      chk_word(nargs[15:0], r.kind == 1 ? {4'h0, r.len - 12'h001} : 16'h0000);
   endtask

   // ==========================================================
   // Sequence: reset, table rows back to back, reset mid-command
   initial begin
      repeat (3) @(posedge sys_clk_in);
      chk_bit(doe, 1'b0);
      @(posedge sys_clk_in) reset_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      foreach (rows[k]) run_cmd(rows[k]);
      pm.send_word(16'h1003);
      pm.release_line();
      @(posedge sys_clk_in) reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      chk_bit(doe, 1'b0);
      reset_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      run_cmd(rows[0]);
      stop_test;
   end

   // Whole run needs about 140 us
   initial begin
      #400000;
      num_errors++;
      stop_test;
   end
endmodule

/* File: rtl/flash_loader_command_link.sv */
/*
 * Device end of the resident_loader command link: receives framed commands
 * from the programmer, splits the header, hands arguments to the executive,
 * signals busy and ready on the shared data pin and shifts the response out.
 * Assumes the executive core answers exec_start_out with exec_done_in and
 * presents resp_word_in for resp_index_out one cycle after it changes.
 */
// What this block does
// - One command at a time, one response each.
// - Change data on falling, sample on rising.
// - Sixteen-bit words, most significant bit first.
// - After command, drive data high while busy.
// - Pull data low when response is ready.
// - No time-out while waiting for response clocks.
// - Header: four-bit opcode over twelve-bit length.
// - Read exactly length words, header included.
// - Refuse unsupported and reserved opcodes with NACK.
// - Opcode one reads config register, three words.
// - Opcode two reads program words, four words.
// - Opcode three programs two words, six words.
// - Opcode five programs a row, ninety-nine words.
// - Opcode seven erases whole chip, one word.
// - Opcode nine erases one page, three words.
// - Opcode eleven returns version, one word.
// - Opcode twelve computes range CRC, five words.
// - Opcode fourteen checks blank memory, five words.
// - Sanity check answers 0x1000 then 0x0002.
// - Argument values pass through unchecked.
`timescale 1ns/1ps
module flash_loader_command_link (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         reset_in,
   // Programmer pins
   input  wire logic         prog_serial_clock_in,
   input  wire logic         prog_serial_data_in,
   output logic              prog_serial_data_out,
   output logic              prog_serial_data_oe_out,
   // Command towards the executive core
   output logic              exec_start_out,
   output logic [3:0]        exec_opcode_out,
   output logic [11:0]       exec_length_out,
   output logic              arg_valid_out,
   output logic [15:0]       arg_word_out,
   output logic [11:0]       arg_index_out,
   // Response from the executive core
   input  wire logic         exec_done_in,
   input  wire logic [11:0]  resp_len_in,
   input  wire logic [15:0]  resp_word_in,
   output logic [11:0]       resp_index_out,
   // Status
   output logic              link_busy_out
);

   link_edge_if            e ();
   link_pkg::link_state_t  state;
   logic [15:0]            rx_shift;
   logic [3:0]             rx_bits;
   logic                   rx_word_valid;
   logic [15:0]            rx_word;
   logic                   hdr_pending;
   logic [11:0]            words_left;
   logic [11:0]            arg_cnt;
   logic                   cmd_complete;
   logic [11:0]            resp_len;
   logic [7:0]             hold_cnt;
   logic [15:0]            tx_shift;
   logic [4:0]             tx_bits;
   logic                   last_word;
   logic                   is_external;
   logic                   is_sanity;
   logic [15:0]            resp_word;

   // ==========================================================
   // Pin front end
   serial_edge_detect edges (
      .sys_clk_in           (sys_clk_in),
      .reset_in             (reset_in),
      .prog_serial_clock_in (prog_serial_clock_in),
      .prog_serial_data_in  (prog_serial_data_in),
      .e                    (e)
   );

   // ==========================================================
   // Opcode classification and response word source
   always_comb begin
      is_sanity   = (exec_opcode_out == link_pkg::OPC_SANITY);
      is_external = link_pkg::opcode_supported(exec_opcode_out) && !is_sanity;
      resp_word   = resp_word_in;
      if (!is_external) begin
         if (is_sanity) begin
            resp_word = (resp_index_out == link_pkg::RESP_IDX0) ?
                        link_pkg::SANITY_RESP0 : link_pkg::SANITY_RESP1;
         end else begin
            resp_word = (resp_index_out == link_pkg::RESP_IDX0) ?
                        link_pkg::nack_header(exec_opcode_out) : link_pkg::NACK_RESP1;
         end
      end
   end

   // ==========================================================
   // Receive shifter: one bit per rising edge, MSB first
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rx_shift      <= 16'h0000;
         rx_bits       <= 4'h0;
         rx_word_valid <= 1'b0;
         rx_word       <= 16'h0000;
      end else begin
         rx_word_valid <= 1'b0;
         if (state != link_pkg::ST_RECEIVE) begin
            rx_bits <= 4'h0;                            // Stray clocks while we drive are not data
         end else if (e.rise) begin
            rx_shift <= {rx_shift[14:0], e.bit_val};
            if (rx_bits == link_pkg::RX_LAST_BIT) begin
               rx_bits       <= 4'h0;
               rx_word_valid <= 1'b1;
               rx_word       <= {rx_shift[14:0], e.bit_val};
            end else begin
               rx_bits <= rx_bits + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Header split and argument hand-off; values are never checked
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         hdr_pending     <= 1'b1;
         words_left      <= 12'h000;
         arg_cnt         <= 12'h000;
         cmd_complete    <= 1'b0;
         exec_opcode_out <= 4'h0;
         exec_length_out <= 12'h000;
         arg_valid_out   <= 1'b0;
         arg_word_out    <= 16'h0000;
         arg_index_out   <= 12'h000;
      end else begin
         arg_valid_out <= 1'b0;
         cmd_complete  <= 1'b0;
         if (rx_word_valid) begin
            if (hdr_pending) begin
               exec_opcode_out <= rx_word[link_pkg::OPC_MSB:link_pkg::OPC_LSB];
               exec_length_out <= rx_word[link_pkg::LEN_MSB:link_pkg::LEN_LSB];
               arg_cnt         <= 12'h000;
               // A zero length is read as the header alone
               if (rx_word[link_pkg::LEN_MSB:link_pkg::LEN_LSB] <= link_pkg::LEN_ONE) begin
                  cmd_complete <= 1'b1;
               end else begin
                  hdr_pending <= 1'b0;
                  words_left  <= rx_word[link_pkg::LEN_MSB:link_pkg::LEN_LSB] - link_pkg::LEN_ONE;
               end
            end else begin
               arg_valid_out <= is_external;
               arg_word_out  <= rx_word;
               arg_index_out <= arg_cnt;
               arg_cnt       <= arg_cnt + 12'h001;
               words_left    <= words_left - 12'h001;
               if (words_left == link_pkg::LEN_ONE) begin
                  cmd_complete <= 1'b1;
                  hdr_pending  <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Link sequencer and data pin driver; the pin only moves in SEND on a
   // falling edge, so the programmer always samples a settled bit.
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state                   <= link_pkg::ST_RECEIVE;
         prog_serial_data_out    <= 1'b0;
         prog_serial_data_oe_out <= 1'b0;
         exec_start_out          <= 1'b0;
         link_busy_out           <= 1'b0;
         resp_len                <= 12'h000;
         resp_index_out          <= 12'h000;
         hold_cnt                <= 8'h00;
         tx_shift                <= 16'h0000;
         tx_bits                 <= 5'h00;
         last_word               <= 1'b0;
      end else begin
         exec_start_out <= 1'b0;
         unique case (state)
            link_pkg::ST_RECEIVE: begin
               if (cmd_complete) begin
                  state         <= link_pkg::ST_TURN;
                  link_busy_out <= 1'b1;
               end
            end
            link_pkg::ST_TURN: begin
               // Wait for the clock to drop so the programmer has released the line
               if (e.fall) begin
                  prog_serial_data_oe_out <= 1'b1;
                  prog_serial_data_out    <= 1'b1;
                  exec_start_out          <= is_external;
                  state                   <= link_pkg::ST_BUSY;
               end
            end
            link_pkg::ST_BUSY: begin
               if (!is_external || exec_done_in) begin
                  // A zero length would wrap the last-word compare to 0xFFF and run 4096 words, so send one word
                  resp_len <= !is_external ? link_pkg::INT_RESP_LEN :
                              (resp_len_in == 12'h000) ? link_pkg::LEN_ONE : resp_len_in;
                  prog_serial_data_out <= 1'b0;
                  resp_index_out       <= link_pkg::RESP_IDX0;
                  hold_cnt             <= link_pkg::READY_HOLD_CYC;
                  state                <= link_pkg::ST_READY;
               end
            end
            link_pkg::ST_READY: begin
               if (hold_cnt != link_pkg::HOLD_ZERO) begin
                  hold_cnt <= hold_cnt - 8'h01;
               end else begin
                  tx_shift             <= resp_word;
                  prog_serial_data_out <= resp_word[15];
                  tx_bits              <= 5'h00;
                  last_word            <= (resp_len == link_pkg::LEN_ONE);
                  state                <= link_pkg::ST_SEND;
               end
            end
            link_pkg::ST_SEND: begin
               // No time-out here: a stalled programmer leaves us waiting
               if (e.rise && tx_bits != link_pkg::TX_WORD_DONE) begin
                  tx_bits <= tx_bits + 5'h01;
                  if (tx_bits == link_pkg::TX_WORD_DONE - 5'h01 && !last_word) begin
                     resp_index_out <= resp_index_out + 12'h001;
                  end
               end else if (e.fall) begin
                  if (tx_bits == link_pkg::TX_WORD_DONE) begin
                     if (last_word) begin
                        prog_serial_data_oe_out <= 1'b0;
                        prog_serial_data_out    <= 1'b0;
                        link_busy_out           <= 1'b0;
                        state                   <= link_pkg::ST_RECEIVE;
                     end else begin
                        tx_shift             <= resp_word;
                        prog_serial_data_out <= resp_word[15];
                        tx_bits              <= 5'h00;
                        last_word            <= (resp_index_out == resp_len - link_pkg::LEN_ONE);
                     end
                  end else if (tx_bits != 5'h00) begin
                     tx_shift             <= {tx_shift[14:0], 1'b0};
                     prog_serial_data_out <= tx_shift[14];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   word_framing_a: assert property (
      state == link_pkg::ST_RECEIVE && e.rise && rx_bits == link_pkg::RX_LAST_BIT |=> rx_word_valid)
      else $error("received word not closed after sixteen bits");

   header_split_a: assert property (
      rx_word_valid && hdr_pending |=> exec_opcode_out == $past(rx_word[15:12])
                                       && exec_length_out == $past(rx_word[11:0]))
      else $error("header not split into opcode and length");

   length_count_a: assert property (
      rx_word_valid && !hdr_pending && words_left == 12'h001 |=> cmd_complete ##1 state == link_pkg::ST_TURN)
      else $error("command not closed after its length");

   busy_high_a: assert property (
      state == link_pkg::ST_TURN && e.fall |=> state == link_pkg::ST_BUSY
                                       && prog_serial_data_oe_out && prog_serial_data_out)
      else $error("data line not driven high while busy");

   ready_low_a: assert property (
      state == link_pkg::ST_READY |-> prog_serial_data_oe_out && !prog_serial_data_out)
      else $error("ready level not low");

   nack_internal_a: assert property (
      exec_start_out |-> link_pkg::opcode_supported(exec_opcode_out) && exec_opcode_out != 4'h0)
      else $error("unsupported opcode passed to the executive");

   sanity_word_a: assert property (
      state == link_pkg::ST_READY && hold_cnt == link_pkg::HOLD_ZERO && is_sanity
      |=> tx_shift == link_pkg::SANITY_RESP0)
      else $error("sanity response header wrong");

   fall_change_a: assert property (
      state == link_pkg::ST_SEND && $past(state) == link_pkg::ST_SEND
      && $changed(prog_serial_data_out) |-> $past(e.fall))
      else $error("data changed away from a falling edge");

   no_timeout_a: assert property (
      state == link_pkg::ST_SEND && !e.fall |=> state == link_pkg::ST_SEND)
      else $error("response abandoned without programmer clocks");

   release_pin_a: assert property (
      state == link_pkg::ST_SEND && last_word && tx_bits == link_pkg::TX_WORD_DONE && e.fall
      |=> !prog_serial_data_oe_out && state == link_pkg::ST_RECEIVE)
      else $error("data line not released after last word");

   single_cmd_a: assert property (
      exec_start_out |=> !exec_start_out [*8])
      else $error("second command started while one is open");

   // Hand-off, response order, busy status and pin ownership
   arg_handoff_a: assert property (
      rx_word_valid && !hdr_pending |=> arg_word_out == $past(rx_word)
                                        && arg_valid_out == $past(is_external))
      else $error("argument word not handed on unchanged");

   resp_advance_a: assert property (
      state == link_pkg::ST_SEND && e.rise && tx_bits == 5'h0f && !last_word
      |=> resp_index_out == $past(resp_index_out) + 12'h001)
      else $error("response index did not move to the next word");

   busy_flag_a: assert property (
      link_busy_out == (state != link_pkg::ST_RECEIVE))
      else $error("busy status out of step with the link");

   quiet_receive_a: assert property (
      state == link_pkg::ST_RECEIVE |-> !prog_serial_data_oe_out)
      else $error("data line driven while receiving");

   ready_cov: cover property (state == link_pkg::ST_READY ##1 state == link_pkg::ST_SEND);
   sanity_cov: cover property (state == link_pkg::ST_SEND && is_sanity && last_word && e.fall && tx_bits == 5'h10);
   nack_cov: cover property (state == link_pkg::ST_SEND && !is_external && !is_sanity && last_word);
   external_cov: cover property (exec_start_out ##[1:1000] exec_done_in);
   args_cov: cover property (arg_valid_out && exec_length_out == link_pkg::LEN_PROG_ROW);

endmodule

/* File: rtl/link_edge_if.sv */
/*
 * Carries the synchronised serial clock edges and data bit from the pin
 * front end to the command link. Assumes both ends run on sys_clk_in.
 */
`timescale 1ns/1ps
interface link_edge_if;
   logic rise;
   logic fall;
   logic bit_val;

   modport src (output rise, output fall, output bit_val);
   modport dst (input rise, input fall, input bit_val);
endinterface

/* File: rtl/link_pkg.sv */
/*
 * Shared constants for the loader command link: word framing, header
 * fields, opcode table, internal responses, pin timing and link states.
 * Assumes a single 200 MHz system clock; no other package is needed.
 */
package link_pkg;

   // ==========================================================
   // Word framing and header fields
   localparam int            WORD_W      = 16;
   localparam int            OPC_MSB     = 15;
   localparam int            OPC_LSB     = 12;
   localparam int            LEN_MSB     = 11;
   localparam int            LEN_LSB     = 0;
   localparam logic [3:0]    RX_LAST_BIT = 4'hf;
   localparam logic [4:0]    TX_WORD_DONE = 5'h10;
   localparam logic [11:0]   LEN_ONE     = 12'h001;

   // ==========================================================
   // Opcodes
   localparam logic [3:0] OPC_SANITY    = 4'h0;
   localparam logic [3:0] OPC_READ_CFG  = 4'h1;
   localparam logic [3:0] OPC_READ_PROG = 4'h2;
   localparam logic [3:0] OPC_PROG_2W   = 4'h3;
   localparam logic [3:0] OPC_PROG_ROW  = 4'h5;
   localparam logic [3:0] OPC_BULK_ERA  = 4'h7;
   localparam logic [3:0] OPC_PAGE_ERA  = 4'h9;
   localparam logic [3:0] OPC_VERSION   = 4'hb;
   localparam logic [3:0] OPC_RANGE_CRC = 4'hc;
   localparam logic [3:0] OPC_BLANK     = 4'he;

   // Documented command lengths in words, header included
   localparam logic [11:0] LEN_SANITY    = 12'h001;
   localparam logic [11:0] LEN_READ_CFG  = 12'h003;
   localparam logic [11:0] LEN_READ_PROG = 12'h004;
   localparam logic [11:0] LEN_PROG_2W   = 12'h006;
   localparam logic [11:0] LEN_PROG_ROW  = 12'h063;
   localparam logic [11:0] LEN_BULK_ERA  = 12'h001;
   localparam logic [11:0] LEN_PAGE_ERA  = 12'h003;
   localparam logic [11:0] LEN_VERSION   = 12'h001;
   localparam logic [11:0] LEN_RANGE_CRC = 12'h005;
   localparam logic [11:0] LEN_BLANK     = 12'h005;

   // ==========================================================
   // Internal responses
   localparam logic [15:0] SANITY_RESP0  = 16'h1000;
   localparam logic [15:0] SANITY_RESP1  = 16'h0002;
   localparam logic [3:0]  NACK_NIBBLE   = 4'h2;
   localparam logic [7:0]  NACK_CODE     = 8'h00;
   localparam logic [15:0] NACK_RESP1    = 16'h0002;
   localparam logic [11:0] INT_RESP_LEN  = 12'h002;
   localparam logic [11:0] RESP_IDX0     = 12'h000;

   // ==========================================================
   // Timing: ready level held before the first response bit
   localparam int          SYS_CLK_MHZ      = 200;
   localparam int          READY_HOLD_NS    = 50;
   localparam int          READY_HOLD_CYC_I = (READY_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  READY_HOLD_CYC   = READY_HOLD_CYC_I[7:0];
   localparam logic [7:0]  HOLD_ZERO        = 8'h00;

   // ==========================================================
   // Link states
   typedef enum logic [4:0] {
      ST_RECEIVE = 5'b00001,
      ST_TURN    = 5'b00010,
      ST_BUSY    = 5'b00100,
      ST_READY   = 5'b01000,
      ST_SEND    = 5'b10000
   } link_state_t;

   // Opcode table membership
   function automatic logic opcode_supported(input logic [3:0] op);
      case (op)
         OPC_SANITY,
         OPC_READ_CFG,
         OPC_READ_PROG,
         OPC_PROG_2W,
         OPC_PROG_ROW,
         OPC_BULK_ERA,
         OPC_PAGE_ERA,
         OPC_VERSION,
         OPC_RANGE_CRC,
         OPC_BLANK: opcode_supported = 1'b1;
         default: opcode_supported = 1'b0;
      endcase
   endfunction

   // First word of the refusal response
   function automatic logic [15:0] nack_header(input logic [3:0] op);
      nack_header = {NACK_NIBBLE, op, NACK_CODE};
   endfunction

endpackage

/* File: rtl/serial_edge_detect.sv */
/*
 * Pin front end: two-flop synchronisers for the programmer clock and data,
 * and one-cycle pulses on each clock edge. Assumes the system clock is far
 * faster than the programmer clock so no edge is missed.
 */
`timescale 1ns/1ps
module serial_edge_detect (
   // Clock and reset
   input  wire logic  sys_clk_in,
   input  wire logic  reset_in,
   // Pins from the programmer
   input  wire logic  prog_serial_clock_in,
   input  wire logic  prog_serial_data_in,
   // Edge events
   link_edge_if.src   e
);

   logic [1:0] clk_sync;
   logic [1:0] dat_sync;
   logic       clk_prev;

   // ==========================================================
   // Synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         clk_sync <= 2'h0;
         dat_sync <= 2'h0;
         clk_prev <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[0], prog_serial_clock_in};
         dat_sync <= {dat_sync[0], prog_serial_data_in};
         clk_prev <= clk_sync[1];
      end
   end

   // ==========================================================
   // Edge pulses, data bit registered every cycle alongside them
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         e.rise    <= 1'b0;
         e.fall    <= 1'b0;
         e.bit_val <= 1'b0;
      end else begin
         e.rise    <= clk_sync[1] & ~clk_prev;
         e.fall    <= ~clk_sync[1] & clk_prev;
         e.bit_val <= dat_sync[1];
      end
   end

endmodule
